/* File: core/utmi_port_pkg.sv */
// shared types and constants for the parallel data port of the transceiver
// Notes on behaviour
// - txvalid rising starts sync on the line
// - txvalid falling starts end of packet
// - txready acknowledges word taken, next accepted
// - sixteen-bit transmit: bus is input, link drives
// - validh high means sixteen bits, low byte
// - sixteen-bit receive: device drives bus outward
// - device drives validh for full or half word
// - rxvalid only when holding register is full
// - rxactive high from start of packet onward
// - rxerror registered one cycle after the line error flag
// - eight-bit mode: transmit low, receive high byte
package utmi_port_pkg;

    localparam int BUS_W = 16;             // shared data bus width
    localparam int BYTE_W = 8;             // one line byte
    localparam int TX_FIFO_DEPTH = 16;     // words queued toward the line

    localparam logic [15:0] DATA_RST = 16'h0000;   // receive bus after reset
    localparam logic [15:0] OE_ALL = 16'hFFFF;     // whole bus driven outward
    localparam logic [15:0] OE_HIGH = 16'hFF00;    // high byte driven outward
    localparam logic [15:0] OE_NONE = 16'h0000;    // bus released
    localparam logic [7:0] BYTE_ZERO = 8'h00;      // filler for empty lanes

    // one transmit word as it sits in the fifo
    typedef struct packed {
        logic hi_valid;                    // upper byte carries payload
        logic [15:0] data;                 // low byte always payload
    } tx_word_s;

    localparam int TX_WORD_W = $bits(tx_word_s);

    // transmit sequencing
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_e;

    // receive sequencing
    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_BUSY = 2'b10
    } rx_state_e;

endpackage : utmi_port_pkg

/* File: core/utmi_tx_fifo.sv */
// synchronous fifo holding transmit words between link and line
`timescale 1ns/1ps
module utmi_tx_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic CLK_I,
    input wire logic CE_I,
    input wire logic RESETN_I,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];         // storage words
    logic [AW:0] wr_ptr_r;                 // write pointer, extra wrap bit
    logic [AW:0] rd_ptr_r;                 // read pointer, extra wrap bit

    wire ptr_same = wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0];
    wire wrap_diff = wr_ptr_r[AW] != rd_ptr_r[AW];
    wire full = ptr_same && wrap_diff;     // every slot occupied
    wire empty = ptr_same && !wrap_diff;   // nothing queued
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];

    // storage needs no reset, only written slots are ever read
    always_ff @(posedge CLK_I) begin
        if (CE_I && push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    // pointer bookkeeping
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (CE_I) begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule : utmi_tx_fifo

/* File: core/utmi_data_handshake.sv */
// parallel data port of the transceiver: transmit and receive handshake
`timescale 1ns/1ps
module utmi_data_handshake
    import utmi_port_pkg::*;
(
    input wire logic CLK_I,                // port clock, also given to link
    input wire logic CE_I,                 // low freezes all state
    input wire logic RESETN_I,             // synchronous, active low
    input wire logic MODE16_I,             // high: 16-bit bidirectional bus
    // link side
    input wire logic TXVALID_I,
    input wire logic [15:0] DATA_I,
    output logic [15:0] DATA_O,
    output logic [15:0] DATA_OE_O,
    input wire logic VALIDH_I,
    output logic VALIDH_O,
    output logic VALIDH_OE_O,
    output logic TXREADY_O,
    output logic RXVALID_O,
    output logic RXACTIVE_O,
    output logic RXERROR_O,
    // line state machine side, transmit
    output logic SYNC_START_O,
    output logic EOP_START_O,
    output logic LTX_VALID_O,
    input wire logic LTX_READY_I,
    output logic [15:0] LTX_DATA_O,
    output logic LTX_HIGH_O,
    // line state machine side, receive
    input wire logic [7:0] LRX_BYTE_I,
    input wire logic LRX_VALID_I,
    input wire logic LRX_SOP_I,
    input wire logic LRX_EOP_I,
    input wire logic LRX_ERR_I
);

    // place received bytes on the bus lanes for the current mode
    function automatic logic [15:0] rx_place(input logic wide,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [15:0] w;
        w = wide ? {hi, lo} : {lo, BYTE_ZERO};
        return w;
    endfunction : rx_place

    tx_state_e tx_state_r;                 // transmit sequencer
    tx_state_e tx_state_nxt;
    rx_state_e rx_state_r;                 // receive sequencer
    rx_state_e rx_state_nxt;

    logic sync_start_r;                    // pulse: begin sync pattern
    logic eop_start_r;                     // pulse: begin end of packet
    logic [15:0] rx_data_r;                // receive holding register
    logic rx_validh_r;                     // upper byte of holding valid
    logic rx_full_r;                       // holding register full, 1 cycle
    logic rx_err_r;                        // error, one cycle after the line flag
    logic [7:0] low_byte_r;                // first byte of a pair
    logic have_low_r;                      // first byte waiting for partner

    // fifo wiring
    tx_word_s push_word;
    tx_word_s pop_word;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // transmit capture: device samples the bus while txvalid is high
    wire push = TXVALID_I && fifo_in_ready;
    // the acknowledge is gated by the enable: while frozen the fifo
    // takes nothing, so an ack then would make the link drop a word
    assign TXREADY_O = push && CE_I;
    assign push_word.hi_valid = MODE16_I && VALIDH_I;
    assign push_word.data = MODE16_I ? DATA_I
                          : {BYTE_ZERO, DATA_I[7:0]};

    // words drain toward the serializer; stalls fill the fifo
    // sixteen words absorb a line stall; when full the ack drops and
    // the link simply holds its word, nothing is lost
    utmi_tx_fifo #(
        .WIDTH(TX_WORD_W),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .CLK_I(CLK_I),
        .CE_I(CE_I),
        .RESETN_I(RESETN_I),
        .in_valid_i(push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(LTX_READY_I),
        .out_data_o(pop_word)
    );

    assign LTX_VALID_O = fifo_out_valid;
    assign LTX_DATA_O = pop_word.data;
    assign LTX_HIGH_O = pop_word.hi_valid;

    // transmit sequencer next state
    always_comb begin
        tx_state_nxt = tx_state_r;
        case (tx_state_r)
            TX_IDLE: begin
                if (TXVALID_I) begin
                    tx_state_nxt = TX_SEND;
                end
            end
            TX_SEND: begin
                if (!TXVALID_I) begin
                    tx_state_nxt = TX_IDLE;
                end
            end
            default: begin
                tx_state_nxt = TX_IDLE;    // recover from a bad code
            end
        endcase
    end

    // decoded transmit edges
    // edges come from the state, not a delayed copy of the input
    wire tx_rise = (tx_state_r == TX_IDLE) && TXVALID_I;
    wire tx_fall = (tx_state_r == TX_SEND) && !TXVALID_I;

    // transmit sequencer and line start pulses
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            tx_state_r <= TX_IDLE;
            sync_start_r <= 1'b0;
            eop_start_r <= 1'b0;
        end else if (CE_I) begin
            tx_state_r <= tx_state_nxt;
            sync_start_r <= tx_rise;
            eop_start_r <= tx_fall;
        end
    end

    assign SYNC_START_O = sync_start_r;
    assign EOP_START_O = eop_start_r;

    // receive sequencer next state; eop wins over a late start
    always_comb begin
        rx_state_nxt = rx_state_r;
        case (rx_state_r)
            RX_IDLE: begin
                if (LRX_SOP_I) begin
                    rx_state_nxt = RX_BUSY;
                end
            end
            RX_BUSY: begin
                if (LRX_EOP_I) begin
                    rx_state_nxt = RX_IDLE;
                end
            end
            default: begin
                rx_state_nxt = RX_IDLE;
            end
        endcase
    end

    wire rx_busy = rx_state_r == RX_BUSY;
    wire rx_byte = rx_busy && LRX_VALID_I;
    // sixteen-bit pairs complete on the second byte
    wire pair_done = rx_byte && MODE16_I && have_low_r;
    wire pair_open = rx_byte && MODE16_I && !have_low_r;
    // a lone first byte is flushed by end of packet as a half word
    wire odd_flush = rx_busy && LRX_EOP_I && have_low_r && !rx_byte;
    wire single = rx_byte && !MODE16_I;
    wire load = pair_done || odd_flush || single;
    wire [15:0] load_data = odd_flush
                          ? {BYTE_ZERO, low_byte_r}
                          : rx_place(MODE16_I, LRX_BYTE_I, low_byte_r);
    wire [15:0] load_data8 = rx_place(1'b0, BYTE_ZERO, LRX_BYTE_I);

    // receive sequencer and byte pairing
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rx_state_r <= RX_IDLE;
            low_byte_r <= BYTE_ZERO;
            have_low_r <= 1'b0;
        end else if (CE_I) begin
            rx_state_r <= rx_state_nxt;
            if (pair_open) begin
                low_byte_r <= LRX_BYTE_I;
            end
            // pair state is dropped at every packet boundary
            if (pair_open) begin
                have_low_r <= 1'b1;
            end else if (pair_done || LRX_EOP_I || !rx_busy) begin
                have_low_r <= 1'b0;
            end
        end
    end

    // receive holding register; full for exactly one cycle per word
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rx_data_r <= DATA_RST;
            rx_validh_r <= 1'b0;
            rx_full_r <= 1'b0;
            rx_err_r <= 1'b0;
        end else if (CE_I) begin
            rx_full_r <= load;
            // error is registered every busy cycle, so it reaches the link with the word only when that byte completes the word
            rx_err_r <= rx_busy && LRX_ERR_I;
            if (load) begin
                rx_data_r <= single ? load_data8 : load_data;
                rx_validh_r <= pair_done;
            end
        end
    end

    // receive is half duplex: a word loaded while the link transmits
    // in sixteen-bit mode is not shown, the bus belongs to the link
    wire rx_show = rx_full_r && !(MODE16_I && TXVALID_I);
    assign RXVALID_O = rx_show;
    assign RXACTIVE_O = rx_busy;
    assign RXERROR_O = rx_err_r;
    assign DATA_O = rx_data_r;
    assign VALIDH_O = rx_validh_r;

    // bus direction: eight-bit mode keeps the high byte outward always
    wire turn_out = MODE16_I && !TXVALID_I && rx_full_r;
    assign DATA_OE_O = !MODE16_I ? OE_HIGH
                     : (turn_out ? OE_ALL : OE_NONE);
    assign VALIDH_OE_O = turn_out;

endmodule : utmi_data_handshake

/* File: testbench/utmi_data_handshake_assertions.sv */
// assertion checker on the data port handshake block
`timescale 1ns/1ps
module utmi_data_handshake_assertions
    import utmi_port_pkg::*;
(
    input wire logic CLK_I,
    input wire logic CE_I,
    input wire logic RESETN_I,
    input wire logic MODE16_I,
    input wire logic TXVALID_I,
    input wire logic [15:0] DATA_I,
    input wire logic [15:0] DATA_O,
    input wire logic [15:0] DATA_OE_O,
    input wire logic VALIDH_I,
    input wire logic VALIDH_O,
    input wire logic VALIDH_OE_O,
    input wire logic TXREADY_O,
    input wire logic RXVALID_O,
    input wire logic RXACTIVE_O,
    input wire logic RXERROR_O,
    input wire logic SYNC_START_O,
    input wire logic EOP_START_O,
    input wire logic LTX_VALID_O,
    input wire logic LTX_READY_I,
    input wire logic [15:0] LTX_DATA_O,
    input wire logic LTX_HIGH_O,
    input wire logic [7:0] LRX_BYTE_I,
    input wire logic LRX_VALID_I,
    input wire logic LRX_SOP_I,
    input wire logic LRX_EOP_I,
    input wire logic LRX_ERR_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic [7:0] tx_lo = DATA_I[7:0]; // low lane of an 8-bit push
    wire logic push_lone = TXVALID_I && TXREADY_O && !LTX_VALID_O; // empty
    sequence s_sop_seen; LRX_SOP_I ##1 RXACTIVE_O; endsequence
    property p_sync; $rose(TXVALID_I) |=> SYNC_START_O; endproperty
    a_sync: assert property (p_sync) else $error("no sync start");
    property p_eop; $fell(TXVALID_I) |=> EOP_START_O; endproperty
    a_eop: assert property (p_eop) else $error("no packet end");
    property p_ready; !TXVALID_I || !LTX_VALID_O
        |-> TXREADY_O == TXVALID_I; endproperty
    a_ready: assert property (p_ready) else $error("bad ack");
    property p_push; push_lone |=> LTX_HIGH_O == ($past(MODE16_I)
        && $past(VALIDH_I)) && LTX_DATA_O == ($past(MODE16_I) ?
        $past(DATA_I) : {BYTE_ZERO, $past(tx_lo)}); endproperty
    a_push: assert property (p_push) else $error("bad head");
    property p_dir_tx; MODE16_I && TXVALID_I
        |-> DATA_OE_O == OE_NONE && !RXVALID_O; endproperty
    a_dir_tx: assert property (p_dir_tx) else $error("bus driven");
    property p_dir_rx; MODE16_I && RXVALID_O
        |-> DATA_OE_O == OE_ALL && VALIDH_OE_O; endproperty
    a_dir_rx: assert property (p_dir_rx) else $error("bus idle");
    property p_byte8; !MODE16_I
        |-> DATA_OE_O == OE_HIGH && DATA_O[7:0] == BYTE_ZERO; endproperty
    a_byte8: assert property (p_byte8) else $error("lane mix");
    property p_rx8; !MODE16_I && RXACTIVE_O && LRX_VALID_I
        |=> RXVALID_O && DATA_O[15:8] == $past(LRX_BYTE_I); endproperty
    a_rx8: assert property (p_rx8) else $error("rx byte");
    property p_sop; LRX_SOP_I |-> s_sop_seen; endproperty
    a_sop: assert property (p_sop) else $error("no rx active");
    property p_err; RXACTIVE_O && LRX_ERR_I |=> RXERROR_O; endproperty
    a_err: assert property (p_err) else $error("no rx error");
endmodule : utmi_data_handshake_assertions
bind utmi_data_handshake utmi_data_handshake_assertions u_chk (.*);

/* File: testbench/utmi_link_model.sv */
// link controller model: latches receive words, counts transmit acks
`timescale 1ns/1ps
module utmi_link_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic txvalid_i,
    input wire logic txready_i,
    input wire logic rxvalid_i,
    input wire logic validh_i,
    input wire logic [15:0] data_i,
    output logic cap_valid_o,
    output logic [16:0] cap_word_o,
    output int ack_cnt_o
);
    // latch on the flagged edge; acks only count inside a transmission
    always_ff @(posedge clk_i) begin
        cap_valid_o <= resetn_i && rxvalid_i;
        if (rxvalid_i) cap_word_o <= {validh_i, data_i};
        if (!resetn_i) ack_cnt_o <= 0;
        else if (txvalid_i && txready_i) ack_cnt_o <= ack_cnt_o + 1;
    end
endmodule : utmi_link_model

/* File: testbench/tb_top.sv */
// self-checking bench for the data port handshake block
`timescale 1ns/1ps
module tb_top;
    import utmi_port_pkg::*;
    logic CLK_I = 0, CE_I = 1, RESETN_I = 0, MODE16_I = 0, TXVALID_I = 0;
    logic LTX_READY_I = 0, LRX_VALID_I = 0, LRX_SOP_I = 0, LRX_EOP_I = 0;
    logic LRX_ERR_I = 0, tx_vh = 0, hold_line = 0, cap_valid;
    logic [7:0] LRX_BYTE_I = 8'h00;
    logic [15:0] tx_data = 16'h0000, DATA_O, DATA_OE_O, LTX_DATA_O;
    logic VALIDH_O, VALIDH_OE_O, TXREADY_O, RXVALID_O, RXACTIVE_O;
    logic RXERROR_O, SYNC_START_O, EOP_START_O, LTX_VALID_O, LTX_HIGH_O;
    logic [16:0] cap_word, q_tx[$], q_rx[$];
    wire logic [15:0] DATA_I = (DATA_OE_O & DATA_O) | (~DATA_OE_O & tx_data);
    wire logic VALIDH_I = VALIDH_OE_O ? VALIDH_O : tx_vh; // shared pin
    int n_errors = 0, n_tests = 0, acks, pushes = 0, k;
    int c_sync = 0, c_eop = 0, c_err = 0, c_act = 0; // seen pulses, cycles
    int x_burst = 0, x_err = 0, x_act = 0; // expected counts
    always #4 CLK_I = ~CLK_I;
    utmi_data_handshake u_dut (.*);
    utmi_link_model u_link (.clk_i(CLK_I), .resetn_i(RESETN_I),
        .txvalid_i(TXVALID_I), .txready_i(TXREADY_O), .rxvalid_i(RXVALID_O),
        .validh_i(VALIDH_O), .data_i(DATA_O), .cap_valid_o(cap_valid),
        .cap_word_o(cap_word), .ack_cnt_o(acks));
    // line side takes words at random unless held off
    always @(posedge CLK_I) LTX_READY_I <= !hold_line && ($urandom % 2);
    task chk(input string what, input logic [16:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task chk_tx(input logic [16:0] exp, got);
        chk("tx word", exp, got);
    endtask : chk_tx
    task chk_rx(input logic [16:0] exp, got);
        chk("rx word", exp, got);
    endtask : chk_rx
    task chk_cnt(input string what, input int exp, got);
        chk(what, 17'(exp), 17'(got));
    endtask : chk_cnt
    task final_report();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // link drives words and holds each until acknowledged
    task tx_burst(input int n);
        bit ok;
        x_burst++;
        for (int i = 0; i < n; i++) begin
            TXVALID_I <= 1'b1;
            tx_data <= 16'($urandom);
            tx_vh <= 1'($urandom);
            ok = 0;
            for (int w = 0; w < 60 && !ok; w++) begin
                @(negedge CLK_I);
                ok = (TXREADY_O === 1'b1);
                @(posedge CLK_I);
            end
            if (!ok) begin
                n_errors++;
                final_report();
            end
            pushes++;
            // expectation from what the link presented, not the bus wire
            q_tx.push_back(MODE16_I ? {tx_vh, tx_data}
                : {9'h000, tx_data[7:0]});
        end
        TXVALID_I <= 1'b0;
        @(posedge CLK_I);
    endtask : tx_burst
    // one received packet; lost words are not expected at the link
    task rx_pkt(input int nb, input bit err, input bit lost);
        logic [7:0] b, lo;
        x_err += err;
        x_act += nb + 1; // active from start edge until end edge
        @(posedge CLK_I);
        LRX_SOP_I <= 1'b1;
        @(posedge CLK_I);
        LRX_SOP_I <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            b = 8'($urandom);
            LRX_VALID_I <= 1'b1;
            LRX_BYTE_I <= b;
            LRX_ERR_I <= err && i == 1;
            if (!MODE16_I) q_rx.push_back({1'b0, b, BYTE_ZERO});
            else if (i % 2 == 0) lo = b;
            else if (!lost) q_rx.push_back({1'b1, b, lo});
            @(posedge CLK_I);
        end
        LRX_VALID_I <= 1'b0;
        LRX_ERR_I <= 1'b0;
        LRX_EOP_I <= 1'b1;
        if (MODE16_I && nb % 2 && !lost) q_rx.push_back({9'h000, lo});
        @(posedge CLK_I);
        LRX_EOP_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
    endtask : rx_pkt
    // watcher: each result seen takes the oldest note off its queue
    always @(negedge CLK_I) begin
        if (RESETN_I && LTX_VALID_O && LTX_READY_I) begin
            if (q_tx.size() == 0) chk_cnt("tx extra", 0, 1);
            else chk_tx(q_tx.pop_front(), {LTX_HIGH_O, LTX_DATA_O});
        end
        if (cap_valid) begin
            if (q_rx.size() == 0) chk_cnt("rx extra", 0, 1);
            else chk_rx(q_rx.pop_front(), cap_word);
        end
        // pulses and active cycles, tallied against the drivers' notes
        if (RESETN_I) begin
            if (SYNC_START_O === 1'b1) c_sync++;
            if (EOP_START_O === 1'b1) c_eop++;
            if (RXERROR_O === 1'b1) c_err++;
            if (RXACTIVE_O === 1'b1) c_act++;
        end
    end
    initial begin
        void'($urandom(32'hE306C05D));
        repeat (4) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        @(posedge CLK_I);
        tx_burst(12);
        rx_pkt(5, 1, 0);
        $display("test eight bit done");
        MODE16_I <= 1'b1;
        @(posedge CLK_I);
        tx_burst(10);
        rx_pkt(5, 1, 0);
        $display("test sixteen bit done");
        fork
            tx_burst(20);
            begin
                @(negedge CLK_I);
                hold_line = 1'b1;
                rx_pkt(4, 0, 1);
                repeat (12) @(negedge CLK_I);
                chk("ready full", 17'h00000, {16'h0000, TXREADY_O});
                hold_line = 1'b0;
            end
        join
        $display("test full and masked done");
        for (k = 0; k < 300 && q_tx.size() > 0; k++) @(posedge CLK_I);
        repeat (4) @(posedge CLK_I);
        chk_cnt("tx left", 0, q_tx.size());
        chk_cnt("rx left", 0, q_rx.size());
        chk_cnt("acks", pushes, acks);
        chk_cnt("sync starts", x_burst, c_sync);
        chk_cnt("packet ends", x_burst, c_eop);
        chk_cnt("rx errors", x_err, c_err);
        chk_cnt("rx active", x_act, c_act);
        $display("test drain done");
        final_report();
    end
endmodule : tb_top
